// ==== pkg/canif_pkg.sv ====
// package for the can interrupt flag and status register block
// assumes one core clock, registers reached over a plain strobe port
package canif_pkg;

    localparam int          CANIF_AW          = 4;
    localparam int          CANIF_DW          = 16;

    // register offsets
    localparam logic [3:0]  CANIF_FLAGS_OFS   = 4'h0;
    localparam logic [3:0]  CANIF_MASK_OFS    = 4'h1;

    // field positions of the flags register
    localparam int          BIT_TX_BUS_OFF    = 13;
    localparam int          BIT_RX_BUS_PASS   = 11;
    localparam int          BIT_TX_WARN       = 10;
    localparam int          BIT_RX_WARN       = 9;
    localparam int          BIT_ANY_WARN      = 8;
    localparam int          BIT_INVALID       = 7;
    localparam int          BIT_WAKEUP        = 6;
    localparam int          BIT_ERROR         = 5;
    localparam int          BIT_FIFO_AF       = 3;
    localparam int          BIT_RX_OVF        = 2;
    localparam int          BIT_RX_BUF        = 1;

    // writable flag bits and live status bits
    localparam logic [15:0] CANIF_FLAG_MASK   = 16'h00EE;
    localparam logic [15:0] CANIF_STATE_MASK  = 16'h2F00;
    localparam logic [15:0] CANIF_FLAGS_RST   = 16'h0000;
    localparam logic [15:0] CANIF_MASK_RST    = 16'h0000;

    // live error state from the protocol engine
    typedef struct packed {
        logic tx_bus_off;
        logic rx_bus_passive;
        logic tx_error_warning;
        logic rx_error_warning;
    } canif_state_type;

    // one-cycle event pulses from the protocol engine
    typedef struct packed {
        logic invalid_message;
        logic wakeup_activity;
        logic fifo_almost_full;
        logic rx_overflow;
        logic rx_buffer;
    } canif_event_type;

endpackage

// ==== design/canif_status.sv ====
// live error-state bits of the flags register
// assumes the state inputs are synchronous levels
`timescale 1ns/100ps
module canif_status (
    // clock and reset
    input  wire logic                     core_clk_i,
    input  wire logic                     rst_n_i,
    // live state
    input  canif_pkg::canif_state_type    state_i,
    // registered status bits and a pulse when any of them rises
    output logic [15:0]                   status_o,
    output logic                          rise_o
);
    import canif_pkg::*;

    logic [15:0] status_ff;
    logic [15:0] nxt_status;
    logic        rise_ff;
    logic        nxt_rise;

    always_comb begin
        nxt_status                  = 16'h0000;
        nxt_status[BIT_TX_BUS_OFF]  = state_i.tx_bus_off;
        nxt_status[BIT_RX_BUS_PASS] = state_i.rx_bus_passive;
        nxt_status[BIT_TX_WARN]     = state_i.tx_error_warning;
        nxt_status[BIT_RX_WARN]     = state_i.rx_error_warning;
        nxt_status[BIT_ANY_WARN]    = state_i.tx_error_warning | state_i.rx_error_warning;
        // error summary is requested on entry into any error state
        nxt_rise                    = |(nxt_status & ~status_ff);
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_ff <= CANIF_FLAGS_RST;
            rise_ff   <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            rise_ff   <= nxt_rise;
        end
    end

    assign status_o = status_ff;
    assign rise_o   = rise_ff;
endmodule

// ==== design/canif_flag.sv ====
// one sticky interrupt flag: set by hardware, cleared by software
// assumes the event is a one-cycle pulse
`timescale 1ns/100ps
module canif_flag (
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    // set and clear
    input  wire logic set_i,
    input  wire logic clr_i,
    // flag
    output logic      flag_o
);
    logic flag_ff;
    logic nxt_flag;

    always_comb begin
        // a set in the clearing cycle wins so no event is lost
        nxt_flag = set_i | (flag_ff & ~clr_i);
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign flag_o = flag_ff;
endmodule

// ==== design/canif_top.sv ====
// can interrupt flag and status register with interrupt mask
// assumes events and state come synchronous from the protocol engine
//
// Notes on behaviour
// - bit 11 follows receiver bus-passive state.
// - bit 10 follows transmitter error-warning state.
// - bit 9 follows receiver error-warning state.
// - bit 8 is high when transmitter or receiver is in warning.
// - bit 7 sets on an invalid message received.
// - bit 5 sets when any error-state bit 13:8 becomes active.
// - bit 3 sets when the receive fifo is almost full.
// - bit 1 sets on a receive buffer event.
// - bit 6 sets on bus wake-up activity.
// - bit 2 sets on receive buffer overflow.
// - bits 15:14, 12, 4 and 0 read as zero.
`timescale 1ns/100ps
module canif_top (
    // clock and reset
    input  wire logic                       core_clk_i,
    input  wire logic                       rst_n_i,
    // register port
    input  wire logic [3:0]                 addr_i,
    input  wire logic [15:0]                wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic [15:0]                     rdata_o,
    // protocol engine
    input  canif_pkg::canif_state_type      state_i,
    input  canif_pkg::canif_event_type      event_i,
    // interrupt
    output logic                            irq_o
);
    import canif_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] status;
    logic        err_rise;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic [15:0] flag_vec;
    logic [15:0] flags_value;
    logic        wr_flags;
    logic        wr_mask;

    logic [15:0] mask_ff;
    logic [15:0] nxt_mask;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic        irq_ff;
    logic        nxt_irq;

    canif_status u_status (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .state_i    (state_i),
        .status_o   (status),
        .rise_o     (err_rise)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        wr_flags              = wr_i && (addr_i == CANIF_FLAGS_OFS);
        wr_mask               = wr_i && (addr_i == CANIF_MASK_OFS);
        set_vec               = 16'h0000;
        set_vec[BIT_INVALID]  = event_i.invalid_message;
        set_vec[BIT_WAKEUP]   = event_i.wakeup_activity;
        set_vec[BIT_ERROR]    = err_rise;
        set_vec[BIT_FIFO_AF]  = event_i.fifo_almost_full;
        set_vec[BIT_RX_OVF]   = event_i.rx_overflow;
        set_vec[BIT_RX_BUF]   = event_i.rx_buffer;
        // writing zero clears a flag; state bits take no write
        clr_vec               = wr_flags ? (~wdata_i & CANIF_FLAG_MASK) : 16'h0000;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_flag
            if (CANIF_FLAG_MASK[gi]) begin : g_impl
                canif_flag u_flag (
                    .core_clk_i (core_clk_i),
                    .rst_n_i    (rst_n_i),
                    .set_i      (set_vec[gi]),
                    .clr_i      (clr_vec[gi]),
                    .flag_o     (flag_vec[gi])
                );
            end else begin : g_none
                assign flag_vec[gi] = 1'b0;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        // unimplemented bits read as zero
        flags_value = (flag_vec & CANIF_FLAG_MASK) | (status & CANIF_STATE_MASK);
        nxt_mask    = wr_mask ? (wdata_i & CANIF_FLAG_MASK) : mask_ff;
        nxt_rdata   = 16'h0000;
        if (rd_i) begin
            unique case (addr_i)
                CANIF_FLAGS_OFS: nxt_rdata = flags_value;
                CANIF_MASK_OFS:  nxt_rdata = mask_ff;
                default:         nxt_rdata = 16'h0000;
            endcase
        end
        // level interrupt from flags only; state bits reach it through bit 5
        nxt_irq     = |(flag_vec & mask_ff);
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mask_ff  <= CANIF_MASK_RST;
            rdata_ff <= 16'h0000;
            irq_ff   <= 1'b0;
        end else begin
            mask_ff  <= nxt_mask;
            rdata_ff <= nxt_rdata;
            irq_ff   <= nxt_irq;
        end
    end

    assign rdata_o = rdata_ff;
    assign irq_o   = irq_ff;
endmodule

// ==== testbench/canif_chk.sv ====
// assertion checker on the canif_top ports
// assumes one clock domain; bound to canif_top below
`timescale 1ns/100ps
module canif_chk
    import canif_pkg::*;
(
    // clock and reset
    input wire logic                  core_clk_i,
    input wire logic                  rst_n_i,
    // register port, engine, interrupt
    input wire logic [3:0]            addr_i,
    input wire logic [15:0]           wdata_i,
    input wire logic                  wr_i,
    input wire logic                  rd_i,
    input wire logic [15:0]           rdata_o,
    input canif_pkg::canif_state_type state_i,
    input canif_pkg::canif_event_type event_i,
    input wire logic                  irq_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire rdf = rd_i && addr_i == CANIF_FLAGS_OFS;
    // a write in between could clear the flag, so none is allowed
    property p_set(ev, int b);
        ev ##1 !wr_i ##1 rdf |=> rdata_o[b];
    endproperty
    ////////////////////////////////////////
    state_bits_a: assert property (rdf && $stable(state_i) && $past(rst_n_i) |=>
        rdata_o[13:9] == {$past(state_i[3]), 1'b0, $past(state_i[2:0])}) else $error("state bits wrong");
    warn_or_a: assert property (rdf |=> rdata_o[8] == (rdata_o[10] | rdata_o[9]))
        else $error("warning summary wrong");
    zero_bits_a: assert property (rd_i |=> (rdata_o & 16'hD011) == 16'h0000)
        else $error("reserved bit set");
    invalid_set_a: assert property (p_set(event_i.invalid_message, BIT_INVALID)) else $error("no flag 7");
    wake_set_a: assert property (p_set(event_i.wakeup_activity, BIT_WAKEUP)) else $error("no flag 6");
    fifo_set_a: assert property (p_set(event_i.fifo_almost_full, BIT_FIFO_AF)) else $error("no flag 3");
    ovf_set_a: assert property (p_set(event_i.rx_overflow, BIT_RX_OVF)) else $error("no flag 2");
    rxbuf_set_a: assert property (p_set(event_i.rx_buffer, BIT_RX_BUF)) else $error("no flag 1");
    err_sum_a: assert property ($rose(state_i[0]) ##1 !wr_i [*3] ##1 rdf |=> rdata_o[BIT_ERROR])
        else $error("no error flag");
    sticky_flags_a: assert property (rdf ##1 !wr_i ##1 rdf |=>
        (rdata_o & $past(rdata_o, 2) & CANIF_FLAG_MASK) == ($past(rdata_o, 2) & CANIF_FLAG_MASK))
        else $error("flag lost without write");
    cover property (rdf ##1 rdata_o[BIT_ERROR]);
    cover property (rdf ##1 rdata_o[13]);
    cover property ($rose(irq_o));
endmodule
bind canif_top canif_chk u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .state_i(state_i), .event_i(event_i), .irq_o(irq_o));

// ==== testbench/tb_canif_top.sv ====
// self-checking bench for canif_top
// assumes a 250 MHz clock; the bench drives every port itself
`timescale 1ns/100ps
module tb_canif_top;
    import canif_pkg::*;
    logic            core_clk_i, rst_n_i, wr_i, rd_i, irq_o;
    logic [3:0]      addr_i, st_m;
    logic [15:0]     wdata_i, rdata_o, flags_m, mask_m, got;
    logic [31:0]     rnd;
    canif_state_type state_i;
    canif_event_type event_i;
    int              fail_count, cmp_count, cyc;
    canif_top uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .state_i(state_i), .event_i(event_i), .irq_o(irq_o));
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [15:0] exp_flags();
        return flags_m | {2'b00, st_m[3], 1'b0, st_m[2:0], |st_m[1:0], 8'h00};
    endfunction
    task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: read %h, expected %h", $time, g, e);
        end
    endtask
    task automatic chk_irq(input logic e);
        cmp_count++;
        if (irq_o !== e) begin
            fail_count++;
            $display("wrong value at %0t: interrupt %b", $time, irq_o);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge core_clk_i);
        wr_i    <= 1'b0;
        if (a == CANIF_FLAGS_OFS) flags_m &= d | ~CANIF_FLAG_MASK;
        if (a == CANIF_MASK_OFS) mask_m = d & CANIF_FLAG_MASK;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge core_clk_i);
        rd_i   <= 1'b0;
        #1 got = rdata_o;
    endtask
    task automatic pulse(input canif_event_type e);
        @(posedge core_clk_i);
        event_i <= e;
        @(posedge core_clk_i);
        event_i <= '0;
        flags_m |= {8'h00, e[4], e[3], 2'b00, e[2], e[1], e[0], 1'b0};
    endtask
    // only a rising state bit raises the error summary, a held state does not
    task automatic set_state(input logic [3:0] s);
        @(posedge core_clk_i);
        state_i <= s;
        if ((s & ~st_m) != 4'h0) flags_m[BIT_ERROR] = 1'b1;
        st_m = s;
        repeat (3) @(posedge core_clk_i);
    endtask
    task automatic tally_and_finish();
        $display("compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////
    initial begin
        {rst_n_i, wr_i, rd_i, addr_i, wdata_i, state_i, event_i} = '0;
        {flags_m, mask_m, st_m} = '0;
        rnd = 32'h713E;
        repeat (6) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rd_reg(CANIF_FLAGS_OFS);
        chk_word(got, CANIF_FLAGS_RST);
        rd_reg(CANIF_MASK_OFS);
        chk_word(got, CANIF_MASK_RST);
        rd_reg(4'h5);
        chk_word(got, 16'h0000);
        wr_reg(CANIF_MASK_OFS, 16'hFFFF);
        for (int i = 0; i < 5; i++) begin
            pulse(canif_event_type'(5'h01 << i));
            rd_reg(CANIF_FLAGS_OFS);
            chk_word(got, exp_flags());
            chk_irq(1'b1);
            wr_reg(CANIF_FLAGS_OFS, ~flags_m);
            rd_reg(CANIF_FLAGS_OFS);
            chk_word(got, 16'h0000);
            chk_irq(1'b0);
        end
        $display("test single events done");
        // address 7 is unmapped, so that write must change nothing
        for (int i = 0; i < 60; i++) begin
            rnd = lfsr(rnd);
            set_state(rnd[8:5]);
            rd_reg(CANIF_FLAGS_OFS);
            chk_word(got, exp_flags());
            pulse(canif_event_type'(rnd[4:0]));
            wr_reg(CANIF_MASK_OFS, rnd[31:16]);
            wr_reg(rnd[9] ? CANIF_FLAGS_OFS : 4'h7, rnd[27:12]);
            rd_reg(CANIF_FLAGS_OFS);
            chk_word(got, exp_flags());
            rd_reg(CANIF_FLAGS_OFS);
            chk_word(got, exp_flags());
            chk_irq(|(flags_m & mask_m));
            // mask readback: only the implemented flag positions may hold a one
            rd_reg(CANIF_MASK_OFS);
            chk_word(got, mask_m);
        end
        $display("test random traffic done");
        tally_and_finish();
    end
endmodule
